// ===== rtl/etl_pkg.sv
package etl_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned LIMIT_W = 4;
  localparam int unsigned THR_N = 3;
  localparam logic [7:0] ADDR_HIGH_PULSE_MIN = 8'h94;
  localparam logic [7:0] ADDR_LOW_PULSE_MAX = 8'h95;
  localparam logic [7:0] ADDR_LOW_PULSE_MIN = 8'h96;
  localparam logic [7:0] ADDR_FAULT_COUNT = 8'h97;
  localparam logic [7:0] ADDR_WRITE_GUARD = 8'hA1;
  localparam logic [7:0] ADDR_CONFIG_VERSION = 8'hA7;
  localparam logic [THR_N-1:0][7:0] THR_ADDRS = {ADDR_LOW_PULSE_MIN, ADDR_LOW_PULSE_MAX, ADDR_HIGH_PULSE_MIN};
  localparam logic [7:0] UNLOCK_KEY = 8'h9B;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam logic LOCKED_RESET = 1'b0;
  localparam int unsigned LOCK_BIT = 0;
  typedef enum logic {LOAD_WAIT, LOAD_DONE} etl_load_t;
endpackage

// ===== rtl/etl_threshold_lock_regs.sv
`timescale 1ns/1ps
// Operation
// [R1] High-pulse minimum threshold, 8-bit read/write
// [R2] Low-pulse maximum threshold, 8-bit read/write
// [R3] Low-pulse minimum threshold, 8-bit read/write
// [R4] Threshold writes accepted only while monitor stopped
// [R5] Fault counter 5-bit read-only, upper bits zero
// [R6] Counter cleared when stopped or host reset
// [R7] Writing key 0x9B unlocks protected registers
// [R8] Writing any other byte locks them
// [R9] Written byte not stored; reads lock bit only
// [R10] Lock bit 0 unlocked, 1 locked; resets 0x00
// [R11] Customer version byte, default from nonvolatile memory
// [R12] Error handling when counter exceeds limit
// [R13] Run bit gates monitor operation
// [R14] Ignored threshold writes leave value unchanged
module etl_threshold_lock_regs
  import etl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [etl_pkg::ADDR_W-1:0] regAddr,
  input wire logic [etl_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [etl_pkg::DATA_W-1:0] regRdata,
  input wire logic monitorRunBit,
  input wire logic [etl_pkg::LIMIT_W-1:0] monitorFaultCountLimit,
  input wire logic monitorFaultEvent,
  input wire logic hostResetEvent,
  input wire logic [etl_pkg::DATA_W-1:0] nvmConfigVersion,
  output logic [etl_pkg::DATA_W-1:0] highPulseMinThreshold,
  output logic [etl_pkg::DATA_W-1:0] lowPulseMaxThreshold,
  output logic [etl_pkg::DATA_W-1:0] lowPulseMinThreshold,
  output logic [etl_pkg::CNT_W-1:0] monitorFaultCounter,
  output logic configLocked,
  output logic errorHandlingStart
);
  import etl_pkg::*;

  function automatic logic wrHit(input logic en, input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
    wrHit = en && (addr == target);
  endfunction

  logic [DATA_W-1:0] thrQ [THR_N];
  logic [DATA_W-1:0] thrD [THR_N];
  logic [CNT_W-1:0] cntQ, cntD;
  logic lockedQ, lockedD;
  logic [DATA_W-1:0] versionQ, versionD;
  etl_load_t loadQ, loadD;
  logic errStartQ, errStartD;
  logic [DATA_W-1:0] rdataQ, rdataD;
  logic thrWriteOk;

  // Thresholds frozen while running or locked
  assign thrWriteOk = !monitorRunBit && !lockedQ; // [R4] [R13]

  genvar gi;
  generate
    for (gi = 0; gi < THR_N; gi++) begin : gThr
      always_comb begin
        thrD[gi] = thrQ[gi];
        if (wrHit(regWrEn, regAddr, THR_ADDRS[gi]) && thrWriteOk) begin // [R1] [R2] [R3] [R4] [R14]
          thrD[gi] = regWdata;
        end
      end
      always_ff @(posedge core_clk) begin
        if (rst) begin
          thrQ[gi] <= RESET_BYTE;
        end else begin
          thrQ[gi] <= thrD[gi];
        end
      end
    end
  endgenerate

  // Fault counter and error handling trigger
  always_comb begin
    cntD = cntQ;
    if (!monitorRunBit || hostResetEvent) begin // [R6] [R13]
      cntD = CNT_ZERO;
    end else if (monitorFaultEvent && cntQ != CNT_MAX) begin
      cntD = cntQ + CNT_ONE;
    end
    errStartD = monitorRunBit && (cntQ > {1'b0, monitorFaultCountLimit}); // [R12]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cntQ <= CNT_ZERO;
      errStartQ <= 1'b0;
    end else begin
      cntQ <= cntD;
      errStartQ <= errStartD;
    end
  end

  // Lock key and version byte
  always_comb begin
    lockedD = lockedQ;
    versionD = versionQ;
    loadD = loadQ;
    if (wrHit(regWrEn, regAddr, ADDR_WRITE_GUARD)) begin
      lockedD = (regWdata != UNLOCK_KEY); // [R7] [R8]
    end
    case (loadQ)
      LOAD_WAIT: begin
        versionD = nvmConfigVersion; // [R11]
        loadD = LOAD_DONE;
      end
      LOAD_DONE: begin
        if (wrHit(regWrEn, regAddr, ADDR_CONFIG_VERSION) && !lockedQ) begin // [R11]
          versionD = regWdata;
        end
      end
      default: begin
        loadD = LOAD_WAIT;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lockedQ <= LOCKED_RESET; // [R10]
      versionQ <= RESET_BYTE;
      loadQ <= LOAD_WAIT;
    end else begin
      lockedQ <= lockedD;
      versionQ <= versionD;
      loadQ <= loadD;
    end
  end

  // Registered read port
  always_comb begin
    rdataD = rdataQ;
    if (regRdEn) begin
      case (regAddr)
        ADDR_HIGH_PULSE_MIN: rdataD = thrQ[0];
        ADDR_LOW_PULSE_MAX: rdataD = thrQ[1];
        ADDR_LOW_PULSE_MIN: rdataD = thrQ[2];
        ADDR_FAULT_COUNT: rdataD = {3'h0, cntQ}; // [R5]
        ADDR_WRITE_GUARD: begin
          rdataD = RESET_BYTE; // [R9]
          rdataD[LOCK_BIT] = lockedQ; // [R10]
        end
        ADDR_CONFIG_VERSION: rdataD = versionQ;
        default: rdataD = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdataQ <= RESET_BYTE;
    end else begin
      rdataQ <= rdataD;
    end
  end

  assign regRdata = rdataQ;
  assign highPulseMinThreshold = thrQ[0];
  assign lowPulseMaxThreshold = thrQ[1];
  assign lowPulseMinThreshold = thrQ[2];
  assign monitorFaultCounter = cntQ;
  assign configLocked = lockedQ;
  assign errorHandlingStart = errStartQ;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  thr_write_a: assert property ( // [R1]
    wrHit(regWrEn, regAddr, ADDR_HIGH_PULSE_MIN) && !monitorRunBit && !lockedQ
    |=> highPulseMinThreshold == $past(regWdata))
    else $error("high pulse threshold write lost");

  thr_frozen_a: assert property ( // [R4]
    monitorRunBit && !wrHit(regWrEn, regAddr, ADDR_LOW_PULSE_MAX) ##1
    monitorRunBit && wrHit(regWrEn, regAddr, ADDR_LOW_PULSE_MAX)
    |=> $stable(lowPulseMaxThreshold))
    else $error("threshold changed while running");

  thr_ignore_a: assert property ( // [R14]
    monitorRunBit && wrHit(regWrEn, regAddr, ADDR_LOW_PULSE_MIN)
    |=> lowPulseMinThreshold == $past(lowPulseMinThreshold))
    else $error("ignored write changed threshold");

  cnt_clear_a: assert property ( // [R6]
    (!monitorRunBit || hostResetEvent) |=> monitorFaultCounter == CNT_ZERO)
    else $error("fault counter not cleared");

  cnt_readonly_a: assert property ( // [R5]
    wrHit(regWrEn, regAddr, ADDR_FAULT_COUNT) && !monitorFaultEvent && monitorRunBit && !hostResetEvent
    |=> $stable(monitorFaultCounter))
    else $error("fault counter written");

  lock_key_a: assert property ( // [R7]
    wrHit(regWrEn, regAddr, ADDR_WRITE_GUARD) && regWdata == UNLOCK_KEY |=> !configLocked)
    else $error("key did not unlock");

  lock_other_a: assert property ( // [R8]
    wrHit(regWrEn, regAddr, ADDR_WRITE_GUARD) && regWdata != UNLOCK_KEY |=> configLocked)
    else $error("other byte did not lock");

  lock_read_a: assert property ( // [R9]
    regRdEn && regAddr == ADDR_WRITE_GUARD
    |=> regRdata == {7'h00, $past(lockedQ)})
    else $error("lock read wrong");

  err_start_a: assert property ( // [R12]
    monitorRunBit && cntQ > {1'b0, monitorFaultCountLimit} |=> errorHandlingStart)
    else $error("error handling not started");

  version_a: assert property ( // [R11]
    loadQ == LOAD_DONE && wrHit(regWrEn, regAddr, ADDR_CONFIG_VERSION) && !lockedQ
    |=> versionQ == $past(regWdata))
    else $error("version write lost");

  thr_low_max_a: assert property ( // [R2]
    wrHit(regWrEn, regAddr, ADDR_LOW_PULSE_MAX) && thrWriteOk |=> lowPulseMaxThreshold == $past(regWdata))
    else $error("low pulse maximum write lost");

  thr_low_min_a: assert property ( // [R3]
    wrHit(regWrEn, regAddr, ADDR_LOW_PULSE_MIN) && thrWriteOk |=> lowPulseMinThreshold == $past(regWdata))
    else $error("low pulse minimum write lost");

  run_hold_a: assert property ( // [R4]
    monitorRunBit |=> $stable(highPulseMinThreshold) && $stable(lowPulseMaxThreshold)
    && $stable(lowPulseMinThreshold))
    else $error("threshold moved while running");

  lock_hold_a: assert property ( // [R8]
    lockedQ && loadQ == LOAD_DONE |=> $stable(highPulseMinThreshold) && $stable(lowPulseMaxThreshold)
    && $stable(lowPulseMinThreshold) && $stable(versionQ))
    else $error("protected register moved while locked");

  lock_steady_a: assert property ( // [R9]
    !wrHit(regWrEn, regAddr, ADDR_WRITE_GUARD) |=> $stable(configLocked))
    else $error("lock state changed without a write");

  lock_bits_a: assert property ( // [R9]
    regRdEn && regAddr == ADDR_WRITE_GUARD |=> regRdata[7:1] == 7'h00)
    else $error("lock read upper bits set");

  cnt_step_a: assert property ( // [R5]
    monitorRunBit && !hostResetEvent && monitorFaultEvent && monitorFaultCounter != CNT_MAX
    |=> monitorFaultCounter == $past(monitorFaultCounter) + CNT_ONE)
    else $error("fault counter did not step");

  cnt_idle_a: assert property ( // [R5]
    monitorRunBit && !hostResetEvent && !monitorFaultEvent |=> $stable(monitorFaultCounter))
    else $error("fault counter moved without a fault");

  cnt_sat_a: assert property ( // [R5]
    monitorRunBit && !hostResetEvent && monitorFaultCounter == CNT_MAX |=> monitorFaultCounter == CNT_MAX)
    else $error("fault counter wrapped");

  count_bits_a: assert property ( // [R5]
    regRdEn && regAddr == ADDR_FAULT_COUNT |=> regRdata[7:5] == 3'h0)
    else $error("fault counter upper bits set");

  count_read_a: assert property ( // [R5]
    regRdEn && regAddr == ADDR_FAULT_COUNT |=> regRdata == {3'h0, $past(monitorFaultCounter)})
    else $error("fault counter read wrong");

  err_quiet_a: assert property ( // [R12]
    !(monitorRunBit && monitorFaultCounter > {1'b0, monitorFaultCountLimit}) |=> !errorHandlingStart)
    else $error("error handling started early");

  err_run_a: assert property ( // [R13]
    !monitorRunBit |=> !errorHandlingStart)
    else $error("error handling while stopped");

  hp_read_a: assert property ( // [R1]
    regRdEn && regAddr == ADDR_HIGH_PULSE_MIN |=> regRdata == $past(highPulseMinThreshold))
    else $error("high pulse minimum read wrong");

  lpmax_read_a: assert property ( // [R2]
    regRdEn && regAddr == ADDR_LOW_PULSE_MAX |=> regRdata == $past(lowPulseMaxThreshold))
    else $error("low pulse maximum read wrong");

  lpmin_read_a: assert property ( // [R3]
    regRdEn && regAddr == ADDR_LOW_PULSE_MIN |=> regRdata == $past(lowPulseMinThreshold))
    else $error("low pulse minimum read wrong");

  version_read_a: assert property ( // [R11]
    regRdEn && regAddr == ADDR_CONFIG_VERSION |=> regRdata == $past(versionQ))
    else $error("version read wrong");

  version_load_a: assert property ( // [R11]
    loadQ == LOAD_WAIT |=> versionQ == $past(nvmConfigVersion))
    else $error("version default not loaded");

  version_hold_a: assert property ( // [R11]
    loadQ == LOAD_DONE && !wrHit(regWrEn, regAddr, ADDR_CONFIG_VERSION) |=> $stable(versionQ))
    else $error("version changed without a write");

  reset_value_a: assert property ( // [R10]
    disable iff (1'b0)
    rst |=> !configLocked && monitorFaultCounter == CNT_ZERO && !errorHandlingStart && regRdata == RESET_BYTE
    && highPulseMinThreshold == RESET_BYTE && lowPulseMaxThreshold == RESET_BYTE && lowPulseMinThreshold == RESET_BYTE)
    else $error("reset values wrong");

  run_hold_c: cover property (monitorRunBit && wrHit(regWrEn, regAddr, ADDR_HIGH_PULSE_MIN));
  err_fire_c: cover property (!errorHandlingStart ##1 errorHandlingStart);
  unlock_c: cover property (configLocked ##1 !configLocked);
  lock_read_c: cover property (regRdEn && regAddr == ADDR_WRITE_GUARD && lockedQ);
  sat_reach_c: cover property (monitorFaultCounter == CNT_MAX);
endmodule

// ===== tb/etl_monitor_model.sv
`timescale 1ns/1ps
module etl_monitor_model (
  input wire logic core_clk,
  input wire logic runReq,
  input wire logic faultReq,
  input wire logic hostRstReq,
  output logic monitorRunBit,
  output logic monitorFaultEvent,
  output logic hostResetEvent
);
  // Start bit follows software, faults only while running
  always_ff @(posedge core_clk) begin
    monitorRunBit <= runReq;
    monitorFaultEvent <= faultReq & runReq;
    hostResetEvent <= hostRstReq;
  end
endmodule

// ===== tb/tb_etl_threshold_lock_regs.sv
`timescale 1ns/1ps
module tb_etl_threshold_lock_regs;
  import etl_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic runReq = 1'b0;
  logic faultReq = 1'b0;
  logic hostRstReq = 1'b0;
  logic [3:0] limit = 4'h2;
  logic [7:0] nvm = 8'h5A;
  logic [7:0] regRdata, hpMin, lpMax, lpMin;
  logic [4:0] cnt;
  logic runBit, faultEv, hostRst, locked, errStart;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  always #5 core_clk = ~core_clk;
  etl_monitor_model i_etl_monitor_model (.core_clk(core_clk), .runReq(runReq), .faultReq(faultReq),
    .hostRstReq(hostRstReq), .monitorRunBit(runBit), .monitorFaultEvent(faultEv), .hostResetEvent(hostRst));
  etl_threshold_lock_regs i_etl_threshold_lock_regs (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdata(regRdata), .monitorRunBit(runBit),
    .monitorFaultCountLimit(limit), .monitorFaultEvent(faultEv), .hostResetEvent(hostRst),
    .nvmConfigVersion(nvm), .highPulseMinThreshold(hpMin), .lowPulseMaxThreshold(lpMax),
    .lowPulseMinThreshold(lpMin), .monitorFaultCounter(cnt), .configLocked(locked),
    .errorHandlingStart(errStart));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    regAddr = a;
    regWdata = d;
    regWrEn = 1'b1;
    cyc(1);
    regWrEn = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    regAddr = a;
    regRdEn = 1'b1;
    cyc(1);
    regRdEn = 1'b0;
    chk(regRdata, exp);
  endtask
  task automatic fault();
    faultReq = 1'b1;
    cyc(1);
    faultReq = 1'b0;
    cyc(2);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
  initial begin
    cyc(5);
    rst = 1'b0;
    cyc(2);
    rchk(ADDR_CONFIG_VERSION, 8'h5A);
    rchk(ADDR_HIGH_PULSE_MIN, RESET_BYTE);
    rchk(ADDR_LOW_PULSE_MAX, RESET_BYTE);
    rchk(ADDR_LOW_PULSE_MIN, RESET_BYTE);
    rchk(ADDR_FAULT_COUNT, RESET_BYTE);
    rchk(ADDR_WRITE_GUARD, RESET_BYTE);
    rchk(8'h50, RESET_BYTE);
    $display("test reset done");
    for (int i = 0; i < 3; i++) wr(THR_ADDRS[i], 8'hA0 + 8'(i));
    chk(hpMin, 8'hA0);
    chk(lpMax, 8'hA1);
    chk(lpMin, 8'hA2);
    rchk(ADDR_LOW_PULSE_MIN, 8'hA2);
    wr(ADDR_FAULT_COUNT, 8'hFF);
    rchk(ADDR_FAULT_COUNT, 8'h00);
    wr(ADDR_CONFIG_VERSION, 8'h3C);
    rchk(ADDR_CONFIG_VERSION, 8'h3C);
    $display("test thresholds done");
    runReq = 1'b1;
    cyc(2);
    wr(ADDR_HIGH_PULSE_MIN, 8'h11);
    wr(ADDR_LOW_PULSE_MAX, 8'h22);
    wr(ADDR_LOW_PULSE_MIN, 8'h33);
    rchk(ADDR_HIGH_PULSE_MIN, 8'hA0);
    chk(lpMax, 8'hA1);
    chk(lpMin, 8'hA2);
    fault();
    fault();
    chk({7'h00, errStart}, 8'h00);
    fault();
    wr(ADDR_FAULT_COUNT, 8'h1F);
    rchk(ADDR_FAULT_COUNT, 8'h03);
    n = 0;
    while (errStart !== 1'b1 && n < 4) begin
      cyc(1);
      n++;
    end
    chk({7'h00, errStart}, 8'h01);
    limit = 4'h3;
    cyc(1);
    chk({7'h00, errStart}, 8'h00);
    hostRstReq = 1'b1;
    cyc(1);
    hostRstReq = 1'b0;
    cyc(2);
    chk({3'h0, cnt}, 8'h00);
    fault();
    chk({3'h0, cnt}, 8'h01);
    repeat (31) fault();
    chk({3'h0, cnt}, {3'h0, CNT_MAX});
    chk({7'h00, errStart}, 8'h01);
    runReq = 1'b0;
    cyc(3);
    chk({3'h0, cnt}, 8'h00);
    chk({7'h00, errStart}, 8'h00);
    $display("test counter done");
    wr(ADDR_WRITE_GUARD, 8'h00);
    rchk(ADDR_WRITE_GUARD, 8'h01);
    chk({7'h00, locked}, 8'h01);
    wr(ADDR_LOW_PULSE_MIN, 8'h77);
    rchk(ADDR_LOW_PULSE_MIN, 8'hA2);
    wr(ADDR_WRITE_GUARD, UNLOCK_KEY);
    rchk(ADDR_WRITE_GUARD, 8'h00);
    wr(ADDR_LOW_PULSE_MIN, 8'h77);
    rchk(ADDR_LOW_PULSE_MIN, 8'h77);
    chk(lpMin, 8'h77);
    $display("test lock done");
    close_out();
  end
endmodule
